// >>> hw/sigm_pkg.sv
// Package: register map, field layout and types of the signal measurement timer core
package sigm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 24;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_CTRL1 = 8'h04;
	localparam logic [7:0] ADDR_CLKSEL = 8'h08;
	localparam logic [7:0] ADDR_FLAGS = 8'h0c;
	localparam logic [7:0] ADDR_COUNTER = 8'h10;
	localparam logic [7:0] ADDR_PERIOD = 8'h14;
	localparam logic [7:0] ADDR_WIDTH_LATCH = 8'h18;
	localparam logic [7:0] ADDR_PERIOD_LATCH = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h28;
	// Flags register bits
	localparam int FLAG_CLEAR = 0;
	localparam int FLAG_WIDTH_LATCH_UPDATE_BIT = 1;
	localparam int FLAG_PERIOD_LATCH_UPDATE_BIT = 2;
	localparam int FLAG_WS = 3;
	localparam int FLAG_AS = 4;
	localparam int FLAG_TS = 5;
	// Control 1 fields
	localparam int CTRL1_RUN = 0;
	localparam int CTRL1_MODE_LSB = 1;
	// Interrupt bits
	localparam int IRQ_W = 3;
	localparam int IRQ_MATCH = 0;
	localparam int IRQ_WIDTH = 1;
	localparam int IRQ_PERIOD = 2;
	// Measurement modes
	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_GATED = 2'h1;
	localparam logic [1:0] MODE_PERDUTY = 2'h2;
	// Clock source codes
	localparam logic [2:0] CSRC_SYS = 3'h0;
	localparam logic [2:0] CSRC_SYS_DIV4 = 3'h1;
	localparam logic [2:0] CSRC_HF = 3'h2;
	localparam logic [2:0] CSRC_MF500K = 3'h3;
	localparam logic [2:0] CSRC_MF31K = 3'h4;
	localparam logic [2:0] CSRC_LF = 3'h5;
	localparam logic [2:0] CSRC_SEC = 3'h6;
	// Reset values and the last state of the divide-by-4 counter
	localparam logic [23:0] CNT_RESET = 24'h00_0000;
	localparam logic [23:0] PERIOD_RESET = 24'hff_ffff;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	// Control 0 layout, low bits first: prescale[1:0], halt, window, signal, clock polarity
	typedef struct packed {
		logic clk_pol;
		logic sig_pol;
		logic win_pol;
		logic halt;
		logic [1:0] prescale_field;
	} sigm_ctrl0_t;
	// Oscillator levels from the clock generator
	typedef struct packed {
		logic hf;
		logic mf500k;
		logic mf31k;
		logic lf;
		logic sec;
	} sigm_osc_t;
endpackage

// >>> hw/sigm_core.sv
// Signal measurement timer core with register port and interrupt
`timescale 1ns/1ns
`default_nettype none
module sigm_core (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire sigm_pkg::sigm_osc_t osc,
	input wire logic window_in,
	input wire logic signal_in,
	output logic irq
);
	sigm_pkg::sigm_ctrl0_t ctrl0_q;
	logic run_q;
	logic [1:0] mode_q;
	logic [2:0] clock_select_field_q;
	logic [23:0] cnt_q;
	logic [23:0] per_q;
	logic [23:0] width_q;
	logic [23:0] perlat_q;
	logic [2:0] irq_stat_q;
	logic [2:0] irq_en_q;
	logic match_hold_q;
	logic [1:0] div4_q;
	logic src_prev_q;
	logic [2:0] pre_q;
	logic win_s1_q, win_s2_q, win_s3_q;
	logic sig_s1_q, sig_s2_q, sig_s3_q;
	logic src_lvl, src_edge, tick;
	logic wr_flags, wr_cnt, do_clear, do_width_latch_update_bit, do_period_latch_update_bit;
	logic win_act, sig_act, sig_rise, sig_fall, win_fall;
	logic count_qual, at_match, step, perduty, gated;
	logic [2:0] irq_set;
	logic [31:0] rd_d;

	// Prescale limit: 1, 2, 4 or 8 source edges per tick
	function automatic logic [2:0] presc_last(input logic [1:0] ps);
		presc_last = 3'((4'h1 << ps) - 4'h1);
	endfunction

	function automatic logic [31:0] pad24(input logic [23:0] v);
		pad24 = {8'h00, v};
	endfunction

	assign wr_flags = wr && (addr == sigm_pkg::ADDR_FLAGS);
	assign wr_cnt = wr && (addr == sigm_pkg::ADDR_COUNTER);
	assign do_clear = wr_flags && wdata[sigm_pkg::FLAG_CLEAR];
	assign do_width_latch_update_bit = wr_flags && wdata[sigm_pkg::FLAG_WIDTH_LATCH_UPDATE_BIT];
	assign do_period_latch_update_bit = wr_flags && wdata[sigm_pkg::FLAG_PERIOD_LATCH_UPDATE_BIT];

	// Control registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl0_q <= '0;
			run_q <= 1'b0;
			mode_q <= sigm_pkg::MODE_TIMER;
			clock_select_field_q <= sigm_pkg::CSRC_SYS;
			per_q <= sigm_pkg::PERIOD_RESET;
			irq_en_q <= '0;
		end else if (wr) begin
			case (addr)
				sigm_pkg::ADDR_CTRL0: ctrl0_q <= sigm_pkg::sigm_ctrl0_t'(wdata[5:0]);
				sigm_pkg::ADDR_CTRL1: begin
					run_q <= wdata[sigm_pkg::CTRL1_RUN];
					mode_q <= wdata[sigm_pkg::CTRL1_MODE_LSB +: 2];
				end
				sigm_pkg::ADDR_CLKSEL: clock_select_field_q <= wdata[2:0];
				sigm_pkg::ADDR_PERIOD: per_q <= wdata[23:0];
				sigm_pkg::ADDR_IRQ_ENABLE: irq_en_q <= wdata[2:0];
				default: ;
			endcase
		end
	end

	// Source selection; slow oscillators arrive as sampled levels
	always_comb begin
		case (clock_select_field_q)
			sigm_pkg::CSRC_HF: src_lvl = osc.hf;
			sigm_pkg::CSRC_MF500K: src_lvl = osc.mf500k;
			sigm_pkg::CSRC_MF31K: src_lvl = osc.mf31k;
			sigm_pkg::CSRC_LF: src_lvl = osc.lf;
			sigm_pkg::CSRC_SEC: src_lvl = osc.sec;
			default: src_lvl = 1'b0;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div4_q <= 2'h0;
			src_prev_q <= 1'b0;
		end else begin
			div4_q <= div4_q + 2'h1;
			src_prev_q <= src_lvl;
		end
	end

	// Clock polarity picks which source edge counts
	always_comb begin
		case (clock_select_field_q)
			sigm_pkg::CSRC_SYS: src_edge = 1'b1;
			sigm_pkg::CSRC_SYS_DIV4: src_edge = (div4_q == sigm_pkg::DIV4_LAST);
			3'h7: src_edge = 1'b0;
			default: src_edge = ctrl0_q.clk_pol ? (src_prev_q && !src_lvl) : (!src_prev_q && src_lvl);
		endcase
	end

	// Prescaler
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pre_q <= 3'h0;
		end else if (src_edge) begin
			pre_q <= (pre_q >= presc_last(ctrl0_q.prescale_field)) ? 3'h0 : pre_q + 3'h1;
		end
	end
	assign tick = src_edge && (pre_q >= presc_last(ctrl0_q.prescale_field));

	// Input synchronisers advance on the prescaled tick only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			win_s1_q <= 1'b0;
			win_s2_q <= 1'b0;
			win_s3_q <= 1'b0;
			sig_s1_q <= 1'b0;
			sig_s2_q <= 1'b0;
			sig_s3_q <= 1'b0;
		end else if (tick) begin
			win_s1_q <= window_in;
			win_s2_q <= win_s1_q;
			win_s3_q <= win_s2_q;
			sig_s1_q <= signal_in;
			sig_s2_q <= sig_s1_q;
			sig_s3_q <= sig_s2_q;
		end
	end

	assign win_act = win_s2_q ^ ctrl0_q.win_pol;
	assign sig_act = sig_s2_q ^ ctrl0_q.sig_pol;
	assign sig_rise = tick && run_q && (sig_act && !(sig_s3_q ^ ctrl0_q.sig_pol));
	assign sig_fall = tick && run_q && (!sig_act && (sig_s3_q ^ ctrl0_q.sig_pol));
	assign win_fall = tick && run_q && (!win_act && (win_s3_q ^ ctrl0_q.win_pol));
	assign gated = (mode_q == sigm_pkg::MODE_GATED);
	assign perduty = (mode_q == sigm_pkg::MODE_PERDUTY);

	// Gated mode counts only inside the active window
	assign count_qual = gated ? win_act : 1'b1;
	assign at_match = (cnt_q == per_q);
	assign step = tick && run_q && count_qual;

	// Counter; a new period restarts it in period/duty mode
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= sigm_pkg::CNT_RESET;
		end else if (do_clear) begin
			cnt_q <= sigm_pkg::CNT_RESET;
		end else if (wr_cnt) begin
			cnt_q <= wdata[23:0];
		end else if (perduty && sig_rise) begin
			cnt_q <= sigm_pkg::CNT_RESET;
		end else if (step) begin
			if (at_match) begin
				if (!ctrl0_q.halt) begin
					cnt_q <= sigm_pkg::CNT_RESET;
				end
			end else begin
				cnt_q <= cnt_q + 24'h1;
			end
		end
	end

	// Halted match keeps the interrupt alive
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			match_hold_q <= 1'b0;
		end else if (do_clear || (wr_cnt && !run_q)) begin
			match_hold_q <= 1'b0;
		end else if (step && at_match && ctrl0_q.halt) begin
			match_hold_q <= 1'b1;
		end
	end

	// Latches; software update and mode trigger both copy the live count
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			width_q <= sigm_pkg::CNT_RESET;
		end else if (do_width_latch_update_bit || (perduty && sig_fall) || (gated && win_fall)) begin
			width_q <= cnt_q;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			perlat_q <= sigm_pkg::CNT_RESET;
		end else if (do_period_latch_update_bit || (perduty && sig_rise)) begin
			perlat_q <= cnt_q;
		end
	end

	// Sticky interrupt status; a set in the clear cycle wins
	assign irq_set[sigm_pkg::IRQ_MATCH] = (step && at_match) || match_hold_q;
	assign irq_set[sigm_pkg::IRQ_WIDTH] = (perduty && sig_fall) || (gated && win_fall);
	assign irq_set[sigm_pkg::IRQ_PERIOD] = perduty && sig_rise;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_stat_q <= '0;
		end else if (wr && (addr == sigm_pkg::ADDR_IRQ_CLEAR)) begin
			irq_stat_q <= (irq_stat_q & ~wdata[2:0]) | irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end
	assign irq = |(irq_stat_q & irq_en_q);

	// Read port, data one cycle after the strobe
	always_comb begin
		case (addr)
			sigm_pkg::ADDR_CTRL0: rd_d = {26'h0, ctrl0_q};
			sigm_pkg::ADDR_CTRL1: rd_d = {29'h0, mode_q, run_q};
			sigm_pkg::ADDR_CLKSEL: rd_d = {29'h0, clock_select_field_q};
			// Level bits read zero while stopped
			sigm_pkg::ADDR_FLAGS: rd_d = {26'h0, run_q, run_q && sig_act, run_q && win_act, 3'h0};
			sigm_pkg::ADDR_COUNTER: rd_d = pad24(cnt_q);
			sigm_pkg::ADDR_PERIOD: rd_d = pad24(per_q);
			sigm_pkg::ADDR_WIDTH_LATCH: rd_d = pad24(width_q);
			sigm_pkg::ADDR_PERIOD_LATCH: rd_d = pad24(perlat_q);
			sigm_pkg::ADDR_IRQ_STATUS: rd_d = {29'h0, irq_stat_q};
			sigm_pkg::ADDR_IRQ_ENABLE: rd_d = {29'h0, irq_en_q};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			rdata <= rd_d;
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// Checks
	sequence seq_quiet;
		!wr_cnt && !do_clear && !(perduty && sig_rise);
	endsequence

	sequence seq_wrap;
		step && at_match && !ctrl0_q.halt ##0 seq_quiet;
	endsequence

	sequence seq_halt_match;
		step && at_match && ctrl0_q.halt ##0 seq_quiet;
	endsequence

	chk_clear_zeroes: assert property (@(posedge clock) disable iff (rst)
		do_clear |=> cnt_q == 24'h00_0000) else $error("counter not cleared");

	chk_wrap_zero: assert property (@(posedge clock) disable iff (rst)
		seq_wrap |=> cnt_q == 24'h00_0000 && irq_stat_q[0]) else $error("no wrap at match");

	chk_halt_stays: assert property (@(posedge clock) disable iff (rst)
		seq_halt_match |=> cnt_q == $past(cnt_q) && match_hold_q) else $error("halt did not stop counter");

	chk_hold_persist: assert property (@(posedge clock) disable iff (rst)
		match_hold_q && !do_clear && !(wr_cnt && !run_q) |=> irq_stat_q[0] ##1 irq_stat_q[0])
		else $error("halted match flag dropped");

	chk_width_copy: assert property (@(posedge clock) disable iff (rst)
		do_width_latch_update_bit |=> width_q == $past(cnt_q)) else $error("width latch not updated");

	chk_period_copy: assert property (@(posedge clock) disable iff (rst)
		do_period_latch_update_bit |=> perlat_q == $past(cnt_q)) else $error("period latch not updated");

	chk_stop_holds: assert property (@(posedge clock) disable iff (rst)
		!run_q && !wr_cnt && !do_clear |=> $stable(cnt_q)) else $error("counter moved while stopped");

	chk_count_step: assert property (@(posedge clock) disable iff (rst)
		step && !at_match ##0 seq_quiet |=> cnt_q == $past(cnt_q) + 24'h1) else $error("counter did not step");

	chk_period_capture: assert property (@(posedge clock) disable iff (rst)
		perduty && sig_rise && !do_period_latch_update_bit && !wr_cnt |=> perlat_q == $past(cnt_q) && cnt_q == 24'h00_0000)
		else $error("period trigger missed");

	chk_status_level: assert property (@(posedge clock) disable iff (rst)
		rd && addr == sigm_pkg::ADDR_FLAGS && run_q |=> rdata[3] == $past(win_act) && rdata[4] == $past(sig_act))
		else $error("level status wrong");

	// A prescale change may shorten the gap, so writes to control 0 are left out
	sequence seq_fast_prescale;
		tick && ctrl0_q.prescale_field != 2'h0 && !(wr && addr == sigm_pkg::ADDR_CTRL0);
	endsequence

	sequence seq_gated_closed;
		gated && tick && run_q && !win_act ##0 seq_quiet;
	endsequence

	sequence seq_width_edge;
		perduty && sig_fall && !do_width_latch_update_bit;
	endsequence

	chk_prescale_gap: assert property (@(posedge clock) disable iff (rst)
		seq_fast_prescale |=> !tick)
		else $error("prescaled tick too early");

	chk_no_source: assert property (@(posedge clock) disable iff (rst)
		clock_select_field_q == 3'h7 |-> !tick)
		else $error("tick without clock source");

	chk_gated_closed: assert property (@(posedge clock) disable iff (rst)
		seq_gated_closed |=> $stable(cnt_q))
		else $error("counter moved outside window");

	chk_width_edge: assert property (@(posedge clock) disable iff (rst)
		seq_width_edge |=> width_q == $past(cnt_q) && irq_stat_q[1])
		else $error("width trigger missed");

	chk_level_stopped: assert property (@(posedge clock) disable iff (rst)
		rd && addr == sigm_pkg::ADDR_FLAGS && !run_q |=> rdata[5:3] == 3'h0)
		else $error("level status set while stopped");

	chk_clear_release: assert property (@(posedge clock) disable iff (rst)
		match_hold_q && do_clear |=> !match_hold_q)
		else $error("halted match not released");

	chk_period_irq: assert property (@(posedge clock) disable iff (rst)
		perduty && sig_rise |=> irq_stat_q[2])
		else $error("period capture status missing");
endmodule
`default_nettype wire

// >>> bench/sigm_src_model.sv
// Partner model: measured signal, window and oscillator sources
`timescale 1ns/1ns
`default_nettype none
module sigm_src_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] hi_len,
	input wire logic [7:0] lo_len,
	input wire logic wave_en,
	input wire logic sig_lvl,
	input wire logic win_lvl,
	output var sigm_pkg::sigm_osc_t osc,
	output logic window_in,
	output logic signal_in
);
	logic [7:0] ph_q;
	logic [4:0] div_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ph_q <= 8'h00;
			div_q <= 5'h00;
		end else begin
			div_q <= div_q + 5'h01;
			ph_q <= (ph_q >= hi_len + lo_len - 8'h01) ? 8'h00 : ph_q + 8'h01;
		end
	end
	// Each oscillator half the rate of the one above
	assign osc = sigm_pkg::sigm_osc_t'({div_q[0], div_q[1], div_q[2], div_q[3], div_q[4]});
	assign signal_in = wave_en ? (ph_q < hi_len) : sig_lvl;
	assign window_in = win_lvl;
endmodule
`default_nettype wire

// >>> bench/signal_measurement_timer_core_tb.sv
// Self-checking bench of the signal measurement timer core
`timescale 1ns/1ns
`default_nettype none
module signal_measurement_timer_core_tb;
	localparam int TICKS [8] = '{160, 40, 80, 40, 20, 10, 5, 0};
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic irq;
	sigm_pkg::sigm_osc_t osc;
	logic window_in;
	logic signal_in;
	logic [7:0] hi_len = 8'h04;
	logic [7:0] lo_len = 8'h04;
	logic wave_en = 1'b0;
	logic sig_lvl = 1'b0;
	logic win_lvl = 1'b0;
	int miscompares = 0;
	int n_compared = 0;
	logic [31:0] seed = 32'h0000_0032;
	logic [31:0] v;
	logic [31:0] p;
	int h;
	int l;
	int e;
	always #5 clock = ~clock;
	sigm_core i_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .osc(osc), .window_in(window_in), .signal_in(signal_in), .irq(irq));
	sigm_src_model i_src (.clock(clock), .rst(rst), .hi_len(hi_len), .lo_len(lo_len),
		.wave_en(wave_en), .sig_lvl(sig_lvl), .win_lvl(win_lvl), .osc(osc),
		.window_in(window_in), .signal_in(signal_in));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		logic [31:0] x;
		x = s;
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic close_out;
		if (miscompares == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Range checks go through the one compare task; a miss reports the low bound
	task automatic chk_rng(input string name, input logic [31:0] got, input int lo, input int hi);
		if ((got >= lo) === 1'b1 && (got <= hi) === 1'b1)
			chk(name, got, got);
		else
			chk(name, got, 32'(lo));
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Clear the count, run n cycles with control 1 set to c1, stop and read the count
	task automatic run_for(input logic [31:0] c1, input int n, output logic [31:0] cnt);
		wr_reg(sigm_pkg::ADDR_FLAGS, 32'h1);
		wr_reg(sigm_pkg::ADDR_CTRL1, c1);
		repeat (n) @(posedge clock);
		wr_reg(sigm_pkg::ADDR_CTRL1, 32'h0);
		rd_reg(sigm_pkg::ADDR_COUNTER, cnt);
	endtask
	initial begin
		repeat (60000) @(posedge clock);
		miscompares++;
		close_out;
	end
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		rd_reg(sigm_pkg::ADDR_PERIOD, v);
		chk("period reset", v, 32'h00ff_ffff);
		rd_reg(sigm_pkg::ADDR_COUNTER, v);
		chk("counter reset", v, 32'h0);
		rd_reg(8'h2c, v);
		chk("unmapped read", v, 32'h0);
		for (int c = 0; c < 8; c++) begin
			wr_reg(sigm_pkg::ADDR_CLKSEL, 32'(c));
			wr_reg(sigm_pkg::ADDR_CTRL0, 32'(c % 2) << 5);
			run_for(32'h1, 160, v);
			e = TICKS[c];
			chk_rng("source count", v, (e > 3) ? e - 3 : 0, (e > 0) ? e + 2 : 0);
		end
		wr_reg(sigm_pkg::ADDR_CLKSEL, 32'h0);
		for (int s = 0; s < 4; s++) begin
			wr_reg(sigm_pkg::ADDR_CTRL0, 32'(s));
			run_for(s[0] ? 32'h7 : 32'h1, 160, v);
			chk_rng("prescaled count", v, (160 >> s) - 3, (160 >> s) + 2);
		end
		wr_reg(sigm_pkg::ADDR_CTRL0, 32'h0);
		seed = nxt(seed);
		p = {8'h00, seed[23:0]};
		wr_reg(sigm_pkg::ADDR_COUNTER, p);
		repeat (20) @(posedge clock);
		rd_reg(sigm_pkg::ADDR_COUNTER, v);
		chk("held counter", v, p);
		wr_reg(sigm_pkg::ADDR_FLAGS, 32'h2);
		rd_reg(sigm_pkg::ADDR_WIDTH_LATCH, v);
		chk("width latch update", v, p);
		wr_reg(sigm_pkg::ADDR_FLAGS, 32'h4);
		rd_reg(sigm_pkg::ADDR_PERIOD_LATCH, v);
		chk("period latch update", v, p);
		wr_reg(sigm_pkg::ADDR_FLAGS, 32'h1);
		rd_reg(sigm_pkg::ADDR_COUNTER, v);
		chk("counter clear", v, 32'h0);
		rd_reg(sigm_pkg::ADDR_FLAGS, v);
		chk("flags stopped", v, 32'h0);
		seed = nxt(seed);
		p = 32'h5 + seed[3:0];
		wr_reg(sigm_pkg::ADDR_PERIOD, p);
		wr_reg(sigm_pkg::ADDR_IRQ_CLEAR, 32'h7);
		wr_reg(sigm_pkg::ADDR_IRQ_ENABLE, 32'h1);
		wr_reg(sigm_pkg::ADDR_CTRL1, 32'h1);
		for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clock);
		if (irq !== 1'b1) begin
			miscompares++;
			close_out;
		end
		rd_reg(sigm_pkg::ADDR_IRQ_STATUS, v);
		chk("match status", v & 32'h1, 32'h1);
		repeat (seed[7:4]) @(posedge clock);
		rd_reg(sigm_pkg::ADDR_COUNTER, v);
		chk_rng("wrapped counter", v, 0, p);
		wr_reg(sigm_pkg::ADDR_IRQ_ENABLE, 32'h0);
		#1 chk("irq masked", {31'h0, irq}, 32'h0);
		wr_reg(sigm_pkg::ADDR_CTRL1, 32'h0);
		wr_reg(sigm_pkg::ADDR_IRQ_CLEAR, 32'h7);
		rd_reg(sigm_pkg::ADDR_IRQ_STATUS, v);
		chk("match cleared", v & 32'h1, 32'h0);
		wr_reg(sigm_pkg::ADDR_CTRL0, 32'h4);
		run_for(32'h1, 3 * p + 30, v);
		chk("halted counter", v, p);
		wr_reg(sigm_pkg::ADDR_IRQ_CLEAR, 32'h1);
		rd_reg(sigm_pkg::ADDR_IRQ_STATUS, v);
		chk("match persists", v & 32'h1, 32'h1);
		wr_reg(sigm_pkg::ADDR_COUNTER, 32'h0);
		wr_reg(sigm_pkg::ADDR_IRQ_CLEAR, 32'h1);
		rd_reg(sigm_pkg::ADDR_IRQ_STATUS, v);
		chk("match released", v & 32'h1, 32'h0);
		// Period far above any window or signal length
		wr_reg(sigm_pkg::ADDR_PERIOD, 32'h00ff_ffff);
		for (int k = 0; k < 3; k++) begin
			win_lvl <= (k > 0);
			wr_reg(sigm_pkg::ADDR_CTRL0, (k == 2) ? 32'h8 : 32'h0);
			run_for(32'h3, 60, v);
			chk_rng("gated count", v, (k == 1) ? 57 : 0, (k == 1) ? 63 : 0);
		end
		wr_reg(sigm_pkg::ADDR_CTRL0, 32'h0);
		for (int k = 0; k < 2; k++) begin
			sig_lvl <= (k == 0);
			win_lvl <= (k == 0);
			wr_reg(sigm_pkg::ADDR_CTRL1, 32'h3);
			repeat (10) @(posedge clock);
			rd_reg(sigm_pkg::ADDR_FLAGS, v);
			chk("level status", v & 32'h38, (k == 0) ? 32'h38 : 32'h20);
			rd_reg(sigm_pkg::ADDR_IRQ_STATUS, v);
			chk("window end capture", v & 32'h2, (k == 0) ? 32'h0 : 32'h2);
		end
		for (int sp = 0; sp < 2; sp++) begin
			seed = nxt(seed);
			h = 4 + seed[2:0];
			l = 4 + seed[6:4];
			hi_len <= 8'(h);
			lo_len <= 8'(l);
			wave_en <= 1'b1;
			wr_reg(sigm_pkg::ADDR_CTRL0, sp ? 32'h10 : 32'h0);
			wr_reg(sigm_pkg::ADDR_IRQ_CLEAR, 32'h7);
			run_for(32'h5, 4 * (h + l) + 5, v);
			rd_reg(sigm_pkg::ADDR_PERIOD_LATCH, v);
			chk_rng("period latch", v, h + l - 2, h + l + 1);
			e = sp ? l : h;
			rd_reg(sigm_pkg::ADDR_WIDTH_LATCH, v);
			chk_rng("width latch", v, e - 2, e + 1);
			rd_reg(sigm_pkg::ADDR_IRQ_STATUS, v);
			chk("capture status", v & 32'h6, 32'h6);
		end
		close_out;
	end
endmodule
`default_nettype wire
